// ### isrp_host.sv
// Link controller: runs one register transaction per APB command
// Assumes an APB master on pclk and the device end on the link interface
`timescale 1ns/100ps
module isrp_host import isrp_pkg::*; #(
	parameter int QUARTER = QUARTER_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link
	isrp_link_if.host link
);
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_START = 2'b01,
		HS_BIT = 2'b10,
		HS_STOP = 2'b11
	} isrp_hstate_t;
	typedef enum logic [2:0] {
		K_AW = 3'b000,
		K_SUB = 3'b001,
		K_WD = 3'b010,
		K_AR = 3'b011,
		K_RD = 3'b100
	} isrp_kind_t;

	isrp_hstate_t hst_q;
	isrp_kind_t kind_q;
	isrp_op_t op_q;
	logic [1:0] phase_q, di_q, last_q;
	logic [7:0] qcnt_q, rx_q, sub_q;
	logic [3:0] bit_q;
	logic [8:0] tx_q;
	logic [31:0] wdata_q, rdata_q, prdata_q;
	logic rs_q, ack_q, scl_oe_q, sda_oe_q, busy_q, nack_q, done_q;
	logic [1:0] sda_sync_q;
	logic sda_s, wr, go;
	logic [1:0] di_nx;

	// ---------------------------------------------------------------
	// APB access
	// ---------------------------------------------------------------
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = prdata_q;
	assign wr = psel && penable && pwrite;
	assign go = wr && paddr == APB_CTRL && pwdata[CTRL_GO_BIT];
	assign di_nx = di_q + 2'd1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else if (psel && !penable) begin
			case (paddr)
				APB_CTRL: prdata_q <= {28'h0000000, last_q, op_q};
				APB_SUB: prdata_q <= {24'h000000, sub_q};
				APB_WDATA: prdata_q <= wdata_q;
				APB_STATUS: prdata_q <= {29'h0000000, done_q, nack_q, busy_q};
				APB_RDATA: prdata_q <= rdata_q;
				default: prdata_q <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sub_q <= 8'h00;
			wdata_q <= 32'h00000000;
		end else if (wr && !busy_q) begin
			if (paddr == APB_SUB)
				sub_q <= pwdata[7:0];
			if (paddr == APB_WDATA)
				wdata_q <= pwdata;
		end
	end

	// ---------------------------------------------------------------
	// Link pins
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sda_sync_q <= 2'b11;
		else
			sda_sync_q <= {sda_sync_q[0], link.sda};
	end
	assign sda_s = sda_sync_q[1];
	assign link.host_scl_o = 1'b0;
	assign link.host_sda_o = 1'b0;
	assign link.host_scl_oe = scl_oe_q;
	assign link.host_sda_oe = sda_oe_q;

	// ---------------------------------------------------------------
	// Transaction engine, four quarters per symbol
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hst_q <= HS_IDLE;
			kind_q <= K_AW;
			op_q <= OP_WRITE;
			phase_q <= 2'd0;
			qcnt_q <= 8'h00;
			bit_q <= 4'd0;
			tx_q <= 9'h1FF;
			rx_q <= 8'h00;
			di_q <= 2'd0;
			last_q <= 2'd0;
			rs_q <= 1'b0;
			ack_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			busy_q <= 1'b0;
			nack_q <= 1'b0;
			done_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end else if (hst_q == HS_IDLE) begin
			if (go) begin
				hst_q <= HS_START;
				busy_q <= 1'b1;
				nack_q <= 1'b0;
				done_q <= 1'b0;
				op_q <= isrp_op_t'(pwdata[CTRL_OP_LSB +: 2]);
				last_q <= pwdata[CTRL_LAST_LSB +: 2];
				rs_q <= 1'b0;
				di_q <= 2'd0;
				phase_q <= 2'd0;
				qcnt_q <= 8'h00;
			end
		end else if (qcnt_q != 8'(QUARTER - 1)) begin
			qcnt_q <= qcnt_q + 8'd1;
		end else begin
			qcnt_q <= 8'h00;
			phase_q <= phase_q + 2'd1;
			case (hst_q)
				HS_START: begin
					case (phase_q)
						2'd0: sda_oe_q <= 1'b0;
						2'd1: scl_oe_q <= 1'b0;
						2'd2: sda_oe_q <= 1'b1;
						default: begin
							scl_oe_q <= 1'b1;
							bit_q <= 4'd0;
							hst_q <= HS_BIT;
							if (op_q == OP_RD_CUR || rs_q) begin
								kind_q <= K_AR;
								tx_q <= {DEV_ADDR, 1'b1, 1'b1};
							end else begin
								kind_q <= K_AW;
								tx_q <= {DEV_ADDR, 1'b0, 1'b1};
							end
						end
					endcase
				end
				HS_BIT: begin
					case (phase_q)
						2'd0: sda_oe_q <= ~tx_q[8];
						2'd1: scl_oe_q <= 1'b0;
						2'd2: begin
							if (bit_q == 4'd8)
								ack_q <= sda_s;
							else
								rx_q <= {rx_q[6:0], sda_s};
						end
						default: begin
							scl_oe_q <= 1'b1;
							tx_q <= {tx_q[7:0], 1'b1};
							bit_q <= bit_q + 4'd1;
							if (bit_q == 4'd8) begin
								bit_q <= 4'd0;
								case (kind_q)
									K_AW: begin
										kind_q <= K_SUB;
										tx_q <= {sub_q, 1'b1};
									end
									K_SUB: begin
										if (op_q == OP_WRITE) begin
											kind_q <= K_WD;
											tx_q <= {wdata_q[7:0], 1'b1};
										end else begin
											rs_q <= 1'b1;
											hst_q <= HS_START;
										end
									end
									K_WD: begin
										if (di_q == last_q) begin
											hst_q <= HS_STOP;
										end else begin
											di_q <= di_nx;
											tx_q <= {wdata_q[{di_nx, 3'b000} +: 8], 1'b1};
										end
									end
									K_AR: begin
										kind_q <= K_RD;
										tx_q <= {8'hFF, last_q == 2'd0};
									end
									default: begin
										rdata_q[{di_q, 3'b000} +: 8] <= rx_q;
										if (di_q == last_q) begin
											hst_q <= HS_STOP;
										end else begin
											di_q <= di_nx;
											tx_q <= {8'hFF, di_nx == last_q};
										end
									end
								endcase
								if (ack_q && kind_q != K_RD) begin
									nack_q <= 1'b1;
									hst_q <= HS_STOP;
								end
							end
						end
					endcase
				end
				HS_STOP: begin
					case (phase_q)
						2'd0: sda_oe_q <= 1'b1;
						2'd1: scl_oe_q <= 1'b0;
						2'd2: sda_oe_q <= 1'b0;
						default: begin
							hst_q <= HS_IDLE;
							busy_q <= 1'b0;
							done_q <= 1'b1;
						end
					endcase
				end
				default: hst_q <= HS_IDLE;
			endcase
		end
	end
endmodule

// ### isrp_pkg.sv
// Shared constants for the two-wire register port and its controller
// Assumes both ends run from a 250 MHz system clock
package isrp_pkg;
	// ---------------------------------------------------------------
	// Target device map
	// ---------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h43;
	localparam int NUM_RW = 9;
	localparam logic [7:0] OFS_REVISION = 8'h00;
	localparam logic [7:0] OFS_IDENTIFIER = 8'h01;
	localparam logic [7:0] OFS_LAST_ERROR = 8'h0F;
	localparam logic [7:0] OFS_SOFT_RESET = 8'h10;
	localparam logic [7:0] OFS_SYNC_STATE = 8'h40;
	localparam logic [7:0] OFS_ANC_LOW = 8'h41;
	localparam logic [7:0] OFS_ANC_HIGH = 8'h42;
	// pll_control, pll_multiplier, pll_input_divider, request_line_polarity,
	// input_clock_edge_select, decode_output_enable, output_silence,
	// command_break, request_line_enable
	localparam logic [7:0] RW_OFS [NUM_RW] = '{8'h05, 8'h06, 8'h07, 8'h0C, 8'h0D,
		8'h13, 8'h14, 8'h16, 8'h18};
	localparam logic [7:0] RW_RST [NUM_RW] = '{8'hA1, 8'h0C, 8'h00, 8'h01, 8'h04,
		8'h01, 8'h00, 8'h00, 8'h00};
	// ---------------------------------------------------------------
	// Controller registers
	// ---------------------------------------------------------------
	localparam logic [7:0] APB_CTRL = 8'h00;
	localparam logic [7:0] APB_SUB = 8'h04;
	localparam logic [7:0] APB_WDATA = 8'h08;
	localparam logic [7:0] APB_STATUS = 8'h0C;
	localparam logic [7:0] APB_RDATA = 8'h10;
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_LAST_LSB = 2;
	localparam int CTRL_GO_BIT = 8;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int LINK_PERIOD_NS = 64;
	localparam int QUARTER_CYC = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
	typedef enum logic [1:0] {
		OP_WRITE = 2'b00,
		OP_RD_RAND = 2'b01,
		OP_RD_CUR = 2'b10
	} isrp_op_t;
endpackage

// ### isrp_link_if.sv
// Two-wire link between controller and register port
// Assumes open-drain wires with pull-ups; enable high with output low pulls the wire low
`timescale 1ns/100ps
interface isrp_link_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// ---------------------------------------------------------------
	// Wire levels
	// ---------------------------------------------------------------
	assign scl = !(host_scl_oe && !host_scl_o);
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
		output host_sda_o, output host_sda_oe);
endinterface

// ### isrp_device.sv
// Two-wire register port: target end with the documented register map
// Assumes the link wires arrive unsynchronised from the controller end
//
// Notes on behaviour
// - target only, never drives clock
// - data changes only while clock low
// - start begins a new transaction
// - stop ends the current transaction
// - receiver pulls data low on ninth
// - sample data on clock rising edge
// - address byte carries 1000011, MSB first
// - address LSB one reads, zero writes
// - acknowledge address only on match
// - first write byte loads sub-address
// - single data byte stored and acknowledged
// - further bytes fill consecutive registers
// - counter increments after every data byte
// - current-address read returns counter register
// - master ack continues, nack ends read
// - all registers eight bits wide
// - registers take reset values at reset
// - master avoids reserved and read-only writes
`timescale 1ns/100ps
module isrp_device import isrp_pkg::*; #(
	// Arbitrary value
	parameter logic [7:0] REVISION = 8'h10,
	// Arbitrary value
	parameter logic [7:0] IDENTIFIER = 8'h5A
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link
	isrp_link_if.dev link,
	// Register contents
	output logic [NUM_RW*8-1:0] rw_regs,
	output logic soft_reset_pulse,
	// Decoder status
	input wire logic [7:0] last_error,
	input wire logic [7:0] frame_sync_state,
	input wire logic [7:0] ancillary_count_low,
	input wire logic [7:0] ancillary_count_high
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_SUB = 3'b010,
		ST_WR = 3'b011,
		ST_RD = 3'b100,
		ST_ACK = 3'b101
	} isrp_dstate_t;

	isrp_dstate_t state_q, nxt_q;
	logic [1:0] scl_sync_q, sda_sync_q;
	logic scl_prev_q, sda_prev_q;
	logic scl_s, sda_s;
	logic scl_rise, scl_fall, start_det, stop_det;
	logic [3:0] cnt_q;
	logic [7:0] shift_q, ptr_q, rd_data;
	logic [3:0] rd_idx, wr_idx;
	logic sda_oe_q, soft_reset_q, wr_en;
	logic [7:0] ctl_q [NUM_RW];

	function automatic logic [3:0] rw_index(input logic [7:0] a);
		rw_index = 4'(NUM_RW);
		for (int i = 0; i < NUM_RW; i++) begin
			if (RW_OFS[i] == a)
				rw_index = 4'(i);
		end
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers and bus conditions
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_sync_q <= 2'b11;
			sda_sync_q <= 2'b11;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], link.scl};
			sda_sync_q <= {sda_sync_q[0], link.sda};
			scl_prev_q <= scl_sync_q[1];
			sda_prev_q <= sda_sync_q[1];
		end
	end
	assign scl_s = scl_sync_q[1];
	assign sda_s = sda_sync_q[1];
	assign scl_rise = scl_s && !scl_prev_q;
	assign scl_fall = !scl_s && scl_prev_q;
	assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
	assign stop_det = scl_s && scl_prev_q && !sda_prev_q && sda_s;

	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe = sda_oe_q;

	// ---------------------------------------------------------------
	// Byte engine
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			nxt_q <= ST_IDLE;
			cnt_q <= 4'd0;
			shift_q <= 8'h00;
			ptr_q <= 8'h00;
			sda_oe_q <= 1'b0;
		end else if (stop_det) begin
			state_q <= ST_IDLE;
			sda_oe_q <= 1'b0;
		end else if (start_det) begin
			state_q <= ST_ADDR;
			cnt_q <= 4'd0;
			sda_oe_q <= 1'b0;
		end else if (scl_rise) begin
			case (state_q)
				ST_ADDR, ST_SUB, ST_WR: begin
					shift_q <= {shift_q[6:0], sda_s};
					cnt_q <= cnt_q + 4'd1;
				end
				ST_RD: begin
					if (cnt_q == 4'd8) begin
						nxt_q <= ST_RD;
						state_q <= sda_s ? ST_IDLE : ST_ACK;
					end else begin
						cnt_q <= cnt_q + 4'd1;
					end
				end
				default: cnt_q <= cnt_q;
			endcase
		end else if (scl_fall) begin
			case (state_q)
				ST_ADDR: begin
					if (cnt_q == 4'd8) begin
						if (shift_q[7:1] == DEV_ADDR) begin
							sda_oe_q <= 1'b1;
							state_q <= ST_ACK;
							nxt_q <= shift_q[0] ? ST_RD : ST_SUB;
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
				ST_SUB: begin
					if (cnt_q == 4'd8) begin
						ptr_q <= shift_q;
						sda_oe_q <= 1'b1;
						state_q <= ST_ACK;
						nxt_q <= ST_WR;
					end
				end
				ST_WR: begin
					if (cnt_q == 4'd8) begin
						ptr_q <= ptr_q + 8'd1;
						sda_oe_q <= 1'b1;
						state_q <= ST_ACK;
						nxt_q <= ST_WR;
					end
				end
				ST_ACK: begin
					cnt_q <= 4'd0;
					state_q <= nxt_q;
					if (nxt_q == ST_RD) begin
						shift_q <= rd_data;
						sda_oe_q <= ~rd_data[7];
					end else begin
						sda_oe_q <= 1'b0;
					end
				end
				ST_RD: begin
					if (cnt_q == 4'd8) begin
						sda_oe_q <= 1'b0;
						ptr_q <= ptr_q + 8'd1;
					end else begin
						shift_q <= {shift_q[6:0], 1'b0};
						sda_oe_q <= ~shift_q[6];
					end
				end
				default: cnt_q <= cnt_q;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------
	assign wr_en = scl_fall && !stop_det && !start_det && state_q == ST_WR && cnt_q == 4'd8;
	assign wr_idx = rw_index(ptr_q);

	for (genvar g = 0; g < NUM_RW; g++) begin : g_rw
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				ctl_q[g] <= RW_RST[g];
			else if (soft_reset_q)
				ctl_q[g] <= RW_RST[g];
			else if (wr_en && wr_idx == 4'(g))
				ctl_q[g] <= shift_q;
		end
		assign rw_regs[g*8 +: 8] = ctl_q[g];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			soft_reset_q <= 1'b0;
		else
			soft_reset_q <= wr_en && ptr_q == OFS_SOFT_RESET;
	end
	assign soft_reset_pulse = soft_reset_q;

	always_comb begin
		rd_idx = rw_index(ptr_q);
		case (ptr_q)
			OFS_REVISION: rd_data = REVISION;
			OFS_IDENTIFIER: rd_data = IDENTIFIER;
			OFS_LAST_ERROR: rd_data = last_error;
			OFS_SYNC_STATE: rd_data = frame_sync_state;
			OFS_ANC_LOW: rd_data = ancillary_count_low;
			OFS_ANC_HIGH: rd_data = ancillary_count_high;
			default: rd_data = (rd_idx < 4'(NUM_RW)) ? ctl_q[rd_idx] : 8'h00;
		endcase
	end
endmodule

// ### isrp_checker.sv
// Link checker: timing relations of the register port on the two-wire link
// Assumes instantiation beside the link interface, on the system clock
`timescale 1ns/100ps
module isrp_checker import isrp_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	// ---------------------------------------------------------------
	// Bus events
	// ---------------------------------------------------------------
	logic scl_q, sda_q, start_w, stop_w, rise_w;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic first_q, match_q, rd_q, mism_q;
	assign start_w = scl && scl_q && sda_q && !sda;
	assign stop_w = scl && scl_q && !sda_q && sda;
	assign rise_w = scl && !scl_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			first_q <= 1'b0;
		end else if (start_w) begin
			bit_q <= 4'h0;
			first_q <= 1'b1;
		end else if (rise_w) begin
			bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
			sh_q <= {sh_q[6:0], sda};
			if (bit_q == 4'h8) begin
				first_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_q <= 1'b0;
			rd_q <= 1'b0;
			mism_q <= 1'b0;
		end else if (start_w || stop_w) begin
			match_q <= 1'b0;
			mism_q <= 1'b0;
		end else if (rise_w && first_q && bit_q == 4'h7) begin
			match_q <= (sh_q[6:0] == DEV_ADDR);
			mism_q <= (sh_q[6:0] != DEV_ADDR);
			rd_q <= sda;
		end
	end
	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_DEV_PULL_ONLY: assert property (dev_sda_oe |-> !dev_sda_o)
		else $error("device drives data high");
	AST_DEV_SDA_SCL_LOW: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
		else $error("device data changed with clock high");
	AST_START_RELEASED: assert property (start_w |-> !dev_sda_oe)
		else $error("device holds data at start");
	AST_STOP_RELEASE: assert property (stop_w |=> !dev_sda_oe [*8])
		else $error("device drives data after stop");
	AST_ADDR_ACK: assert property (
		rise_w && first_q && bit_q == 4'h8 && match_q |-> !sda && dev_sda_oe)
		else $error("matching address not acknowledged");
	AST_WRITE_ACK: assert property (rise_w && bit_q == 4'h8 && match_q && !rd_q |-> dev_sda_oe)
		else $error("written byte not acknowledged");
	AST_READ_SLOT_FREE: assert property (
		rise_w && bit_q == 4'h8 && match_q && rd_q && !first_q |-> !dev_sda_oe)
		else $error("device holds data in master acknowledge slot");
	AST_NOMATCH_SILENT: assert property (mism_q |-> !dev_sda_oe)
		else $error("device drives data after address mismatch");
	AST_HOST_SDA_EDGE: assert property ($changed(host_sda_oe) && scl |-> start_w || stop_w)
		else $error("controller data changed with clock high");
	AST_HOST_PULL_ONLY: assert property (!(host_scl_oe && host_scl_o) && !(host_sda_oe && host_sda_o))
		else $error("controller drives a line high");
	cover property (start_w);
	cover property (stop_w);
	cover property (rise_w && bit_q == 4'h8 && match_q && rd_q && !first_q && !sda);
	cover property (rise_w && bit_q == 4'h8 && match_q && !rd_q && !first_q);
endmodule

// ### i2c_slave_register_port_test.sv
// Testbench: controller and register port joined by one link, a second port bit-banged
// Assumes the package constants and the controller register layout of the hand-over
`timescale 1ns/100ps
module i2c_slave_register_port_test import isrp_pkg::*; ;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, srp, bscl_oe, bsda_oe, ack;
	logic [7:0] paddr, err_v, sync_v, anl_v, anh_v;
	logic [31:0] pwdata, prdata, rd;
	logic [71:0] rw_regs;
	int fail_count = 0;
	int checked = 0;
	int pulses = 0;
	int p0;
	isrp_link_if link_a();
	isrp_link_if link_b();
	assign link_b.host_scl_o = 1'b0;
	assign link_b.host_sda_o = 1'b0;
	assign link_b.host_scl_oe = bscl_oe;
	assign link_b.host_sda_oe = bsda_oe;
	// ---------------------------------------------------------------
	// Design and checker
	// ---------------------------------------------------------------
	isrp_host u_isrp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link_a));
	isrp_device u_isrp_device (.pclk(pclk), .presetn(presetn), .link(link_a), .rw_regs(rw_regs),
		.soft_reset_pulse(srp), .last_error(err_v), .frame_sync_state(sync_v),
		.ancillary_count_low(anl_v), .ancillary_count_high(anh_v));
	isrp_device u_isrp_device_b (.pclk(pclk), .presetn(presetn), .link(link_b), .rw_regs(),
		.soft_reset_pulse(), .last_error(err_v), .frame_sync_state(sync_v),
		.ancillary_count_low(anl_v), .ancillary_count_high(anh_v));
	isrp_checker u_isrp_checker (.pclk(pclk), .presetn(presetn), .host_scl_o(link_a.host_scl_o),
		.host_scl_oe(link_a.host_scl_oe), .host_sda_o(link_a.host_sda_o),
		.host_sda_oe(link_a.host_sda_oe), .dev_sda_o(link_a.dev_sda_o),
		.dev_sda_oe(link_a.dev_sda_oe), .scl(link_a.scl), .sda(link_a.sda));
	// ---------------------------------------------------------------
	// Clock, monitors and watchdog
	// ---------------------------------------------------------------
	logic mscl_q = 1'b1;
	logic msda_q = 1'b1;
	logic [3:0] mbit = 4'h8;
	logic [7:0] msh = 8'h00;
	logic [7:0] mon_q = 8'h00;
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (srp === 1'b1) pulses <= pulses + 1;
		mscl_q <= link_a.scl;
		msda_q <= link_a.sda;
		if (mscl_q && link_a.scl && msda_q && !link_a.sda) begin
			mbit <= 4'h0;
		end else if (link_a.scl && !mscl_q && mbit < 4'h8) begin
			msh <= {msh[6:0], link_a.sda};
			mbit <= mbit + 4'h1;
			if (mbit == 4'h7) mon_q <= {msh[6:0], link_a.sda};
		end
	end
	initial begin
		#200000;
		fail_count++;
		final_report();
	end
	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic final_report();
		if (fail_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic run(input isrp_op_t op, input logic [1:0] last, input logic [7:0] sub,
		input logic [31:0] wd, output logic [31:0] q);
		logic [31:0] st;
		apb(1'b1, APB_SUB, {24'h0, sub}, st);
		apb(1'b1, APB_WDATA, wd, st);
		apb(1'b1, APB_CTRL, 32'h100 | {28'h0, last, op}, st);
		st = 32'h1;
		while (st[0] !== 1'b0) apb(1'b0, APB_STATUS, 32'h0, st);
		check("status", 32'h4, st & 32'h7);
		check("address byte", {24'h0, DEV_ADDR, op != OP_WRITE}, {24'h0, mon_q});
		apb(1'b0, APB_RDATA, 32'h0, q);
	endtask
	task automatic bb_step(input logic c, input logic d);
		bscl_oe <= c;
		bsda_oe <= d;
		repeat (QUARTER_CYC) @(posedge pclk);
	endtask
	task automatic bb_byte(input logic [7:0] v, output logic a);
		logic [8:0] s;
		s = {v, 1'b1};
		for (int i = 8; i >= 0; i--) begin
			bb_step(1'b1, !s[i]);
			bb_step(1'b0, !s[i]);
			if (i == 0) a = link_b.sda;
			bb_step(1'b0, !s[i]);
			bb_step(1'b1, !s[i]);
		end
	endtask
	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, bscl_oe, bsda_oe} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		{err_v, sync_v, anl_v, anh_v} = 32'h023C967E;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		for (int g = 0; g < NUM_RW; g++) begin
			check("rw reset", {24'h0, RW_RST[g]}, {24'h0, rw_regs[g*8 +: 8]});
			run(OP_RD_RAND, 2'd0, RW_OFS[g], 32'h0, rd);
			check("reset read", {24'h0, RW_RST[g]}, rd & 32'hFF);
		end
		run(OP_RD_RAND, 2'd1, OFS_REVISION, 32'h0, rd);
		check("id pair", 32'h5A10, rd & 32'hFFFF);
		run(OP_RD_RAND, 2'd1, OFS_SYNC_STATE, 32'h0, rd);
		check("status run", {16'h0, anl_v, sync_v}, rd & 32'hFFFF);
		run(OP_RD_CUR, 2'd0, 8'h00, 32'h0, rd);
		check("next current", {24'h0, anh_v}, rd & 32'hFF);
		run(OP_RD_RAND, 2'd0, OFS_LAST_ERROR, 32'h0, rd);
		check("error read", {24'h0, err_v}, rd & 32'hFF);
		run(OP_WRITE, 2'd2, RW_OFS[0], 32'h44332211, rd);
		check("multi write", 32'h00332211, {8'h0, rw_regs[23:0]});
		run(OP_WRITE, 2'd0, RW_OFS[3], 32'h05, rd);
		check("single write", 32'h05, {24'h0, rw_regs[31:24]});
		run(OP_RD_CUR, 2'd0, 8'h00, 32'h0, rd);
		check("current read", {24'h0, RW_RST[4]}, rd & 32'hFF);
		p0 = pulses;
		run(OP_WRITE, 2'd0, OFS_SOFT_RESET, 32'h0, rd);
		check("soft pulses", 32'h1, 32'(pulses - p0));
		check("soft reload", {8'h0, RW_RST[2], RW_RST[1], RW_RST[0]},
			{8'h0, rw_regs[23:0]});
		bb_step(1'b0, 1'b0);
		bb_step(1'b0, 1'b1);
		bb_step(1'b1, 1'b1);
		bb_byte(8'h88, ack);
		check("mismatch ack", 32'h1, {31'h0, ack});
		bb_byte(8'h86, ack);
		check("ignored ack", 32'h1, {31'h0, ack});
		bb_step(1'b1, 1'b1);
		bb_step(1'b0, 1'b1);
		bb_step(1'b0, 1'b0);
		bb_step(1'b0, 1'b0);
		bb_step(1'b0, 1'b1);
		bb_step(1'b1, 1'b1);
		bb_byte(8'h86, ack);
		check("match ack", 32'h0, {31'h0, ack});
		final_report();
	end
endmodule
